//--- rtl/crystal_pll_translation.sv
// crystal code to pll setting translation with its register port
`timescale 1ns/100ps
`include "crystal_select_pll_consts.svh"
module crystal_pll_translation (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire crystal_select_pll_pkg::reg_addr_t ADDR_I,
  input wire crystal_select_pll_pkg::reg_data_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output crystal_select_pll_pkg::reg_data_t RDATA_O,
  output crystal_select_pll_pkg::crystal_code_t CRYSTAL_SELECT_O,
  output crystal_select_pll_pkg::post_divide_t PLL_POST_DIVIDE_O,
  output crystal_select_pll_pkg::feedback_t PLL_FEEDBACK_O,
  output crystal_select_pll_pkg::ref_divide_t PLL_REF_DIVIDE_O
);
  import crystal_select_pll_pkg::*;

  crystal_code_t crystal_select_ff;
  post_divide_t pll_post_divide_ff;
  feedback_t feedback_ff;
  ref_divide_t ref_divide_ff;
  reg_data_t rdata_ff;
  reg_data_t nxt_rdata;
  logic code_valid;
  feedback_t nxt_feedback;
  ref_divide_t nxt_ref_divide;

  // crystal select field, the only writable bits held here
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      crystal_select_ff <= `CRYSTAL_SELECT_RST;
    end else if (WR_I && ADDR_I == `RUN_CLOCK_CONFIG_OFS) begin
      crystal_select_ff <= WDATA_I[`CRYSTAL_SELECT_MSB:`CRYSTAL_SELECT_LSB];
    end
  end

  // settings aim the pll at about 400 MHz: crystal / (ref + 2) * (feedback + 2)
  always_comb begin
    code_valid = 1'b1;
    nxt_feedback = feedback_ff;
    nxt_ref_divide = ref_divide_ff;
    unique case (crystal_select_ff)
      4'h4: begin nxt_ref_divide = 5'h01; nxt_feedback = 9'h14d; end
      4'h5: begin nxt_ref_divide = 5'h01; nxt_feedback = 9'h144; end
      4'h6: begin nxt_ref_divide = 5'h02; nxt_feedback = 9'h18e; end
      4'h7: begin nxt_ref_divide = 5'h02; nxt_feedback = 9'h185; end
      4'h8: begin nxt_ref_divide = 5'h03; nxt_feedback = 9'h195; end
      4'h9: begin nxt_ref_divide = 5'h03; nxt_feedback = 9'h18e; end
      4'ha: begin nxt_ref_divide = 5'h03; nxt_feedback = 9'h185; end
      4'hb: begin nxt_ref_divide = 5'h04; nxt_feedback = 9'h18e; end
      4'hc: begin nxt_ref_divide = 5'h04; nxt_feedback = 9'h185; end
      4'hd: begin nxt_ref_divide = 5'h05; nxt_feedback = 9'h17a; end
      4'he: begin nxt_ref_divide = 5'h06; nxt_feedback = 9'h18e; end
      4'hf: begin nxt_ref_divide = 5'h06; nxt_feedback = 9'h185; end
      // reserved codes keep what was there
      4'h0, 4'h1, 4'h2, 4'h3: begin
        code_valid = 1'b0;
      end
    endcase
  end

  // translated settings, recomputed in the cycle after every change to a valid crystal code (4 to f)
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pll_post_divide_ff <= `POST_DIVIDE_RST;
      feedback_ff <= `FEEDBACK_RST;
      ref_divide_ff <= `REF_DIVIDE_RST;
    end else if (code_valid) begin
      pll_post_divide_ff <= `POST_DIVIDE_RST;
      feedback_ff <= nxt_feedback;
      ref_divide_ff <= nxt_ref_divide;
    end
  end

  // read mux; writes to the translation register are ignored
  always_comb begin
    nxt_rdata = `READ_ZERO;
    if (ADDR_I == `RUN_CLOCK_CONFIG_OFS) begin
      nxt_rdata[`CRYSTAL_SELECT_MSB:`CRYSTAL_SELECT_LSB] = crystal_select_ff;
    end else if (ADDR_I == `CRYSTAL_PLL_TRANSLATION_OFS) begin
      nxt_rdata[`POST_DIVIDE_MSB:`POST_DIVIDE_LSB] = pll_post_divide_ff;
      nxt_rdata[`FEEDBACK_MSB:`FEEDBACK_LSB] = feedback_ff;
      nxt_rdata[`REF_DIVIDE_MSB:`REF_DIVIDE_LSB] = ref_divide_ff;
      // upper half reads zero and holds no storage
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_ff <= `READ_ZERO;
    end else if (RD_I) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `READ_ZERO;
    end
  end

  assign RDATA_O = rdata_ff;
  assign CRYSTAL_SELECT_O = crystal_select_ff;
  assign PLL_POST_DIVIDE_O = pll_post_divide_ff;
  assign PLL_FEEDBACK_O = feedback_ff;
  assign PLL_REF_DIVIDE_O = ref_divide_ff;
endmodule : crystal_pll_translation

//--- rtl/crystal_select_pll_consts.svh
// offsets, field positions and reset values of the crystal translation block
`ifndef CRYSTAL_SELECT_PLL_CONSTS_SVH
`define CRYSTAL_SELECT_PLL_CONSTS_SVH
`define RUN_CLOCK_CONFIG_OFS 12'h0060
`define CRYSTAL_PLL_TRANSLATION_OFS 12'h0064
`define CRYSTAL_SELECT_LSB 6
`define CRYSTAL_SELECT_MSB 9
`define CRYSTAL_SELECT_RST 4'hb
`define POST_DIVIDE_LSB 14
`define POST_DIVIDE_MSB 15
`define FEEDBACK_LSB 5
`define FEEDBACK_MSB 13
`define REF_DIVIDE_LSB 0
`define REF_DIVIDE_MSB 4
`define POST_DIVIDE_RST 2'h0
`define FEEDBACK_RST 9'h18e
`define REF_DIVIDE_RST 5'h04
`define READ_ZERO 32'h0000_0000
`endif

//--- rtl/crystal_select_pll_pkg.sv
// types shared by the crystal translation block
package crystal_select_pll_pkg;
  typedef logic [11:0] reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef logic [3:0] crystal_code_t;
  typedef logic [1:0] post_divide_t;
  typedef logic [8:0] feedback_t;
  typedef logic [4:0] ref_divide_t;
endpackage : crystal_select_pll_pkg

//--- sim/crystal_select_pll_mon_monitor.sv
// port assertions for the crystal translation block
`timescale 1ns/100ps
module crystal_select_pll_mon (
  input wire logic CLOCK_I, NRST_I, WR_I, RD_I,
  input wire logic [11:0] ADDR_I, input wire logic [31:0] WDATA_I, RDATA_O,
  input wire logic [3:0] CRYSTAL_SELECT_O, input wire logic [1:0] PLL_POST_DIVIDE_O,
  input wire logic [8:0] PLL_FEEDBACK_O, input wire logic [4:0] PLL_REF_DIVIDE_O);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  wire logic sw = WR_I && ADDR_I == 12'h060, rt = RD_I && ADDR_I == 12'h064;
  wire logic rc = RD_I && ADDR_I == 12'h060;
  wire logic [15:0] pw = {PLL_POST_DIVIDE_O, PLL_FEEDBACK_O, PLL_REF_DIVIDE_O};
  wire logic [3:0] cs = CRYSTAL_SELECT_O;
  a_sel_write: assert property (sw |=> cs == $past(WDATA_I[9:6])) else $error("sel");
  a_sel_hold: assert property (!sw |=> $stable(cs)) else $error("hold");
  a_rd_idle: assert property (!RD_I |=> RDATA_O == 0) else $error("idle");
  a_rd_xlat: assert property (rt |=> RDATA_O == {16'h0, $past(pw)}) else $error("xlat");
  a_rd_sel: assert property (rc |=> RDATA_O == {22'h0, $past(cs), 6'h0}) else $error("rd");
  a_rd_unmap: assert property (RD_I && !rt && !rc |=> RDATA_O == 0) else $error("map");
  a_rsvd_keep: assert property (cs < 4 |=> $stable(pw)) else $error("rsvd");
  a_code_map: assert property (cs == 4'hb |=> pw == 16'h31c4) else $error("b");
  cover property (sw ##1 cs < 4);
  cover property (rt);
  cover property (rc);
endmodule : crystal_select_pll_mon

//--- sim/tb_crystal_pll_translation.sv
// random register traffic for the crystal translation block
`timescale 1ns/100ps
module tb_crystal_pll_translation;
  logic CLOCK_I = 0, NRST_I = 0, WR_I = 0, RD_I = 0;
  logic [11:0] ADDR_I = 0;
  logic [31:0] WDATA_I = 0, RDATA_O;
  logic [3:0] CRYSTAL_SELECT_O, c;
  logic [1:0] PLL_POST_DIVIDE_O;
  logic [8:0] PLL_FEEDBACK_O;
  logic [4:0] PLL_REF_DIVIDE_O;
  int errors = 0, checks_done = 0, seed = 63170, i;
  logic [15:0] tbl [4:15] = '{16'h29a1, 16'h2881, 16'h31c2, 16'h30a2, 16'h32a3, 16'h31c3,
    16'h30a3, 16'h31c4, 16'h30a4, 16'h2f45, 16'h31c6, 16'h30a6};
  always #2 CLOCK_I = ~CLOCK_I;
  crystal_pll_translation u_dut (.*);
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK_I) {WR_I, RD_I, ADDR_I, WDATA_I} <= {w, !w, a, d};
    @(posedge CLOCK_I) {WR_I, RD_I} <= 2'b00;
    #1 checks_done += !w;
    errors += !w && RDATA_O !== d;
    if (!w && RDATA_O !== d) $display("Error rd %h exp %h got %h", a, d, RDATA_O);
  endtask : bus
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge CLOCK_I);
    NRST_I <= 1;
    for (i = 0; i < 40; i++) begin
      c = (i < 4) ? i[3:0] : 4'(4 + {$random(seed)} % 12);
      bus(1, 12'h060, ($random(seed) & 32'hffff_fc3f) | {c, 6'h0});
      bus(1, 12'h064, $random(seed) & 32'h0000_ffff);
      bus(0, 12'h064, tbl[(i < 4) ? 4'hb : c]);
      checks_done += 2;
      if ({PLL_POST_DIVIDE_O, PLL_FEEDBACK_O, PLL_REF_DIVIDE_O} !== tbl[(i < 4) ? 4'hb : c]) begin
        errors++;
        $display("Error pll pins exp %h got %h", tbl[(i < 4) ? 4'hb : c], {PLL_POST_DIVIDE_O, PLL_FEEDBACK_O, PLL_REF_DIVIDE_O});
      end
      if (CRYSTAL_SELECT_O !== c) begin
        errors++;
        $display("Error crystal select exp %h got %h", c, CRYSTAL_SELECT_O);
      end
      bus(0, 12'h060, {c, 6'h0});
      bus(0, 12'h068 + 12'(i * 4), 0);
    end
    $display("register sweep done");
    tally_and_finish();
  end
endmodule : tb_crystal_pll_translation
bind crystal_pll_translation crystal_select_pll_mon u_mon (.*);
